/* jib_defs.svh */
`ifndef JIB_DEFS_SVH
`define JIB_DEFS_SVH

// identification word layout, marker bit at the bottom
`define JIB_ID_W 32
`define JIB_ID_MARK_POS 0
`define JIB_ID_MAKER_LSB 1
`define JIB_ID_MAKER_W 11
`define JIB_ID_PART_LSB 12
`define JIB_ID_PART_W 10
`define JIB_ID_CENTER_LSB 22
`define JIB_ID_CENTER_W 6
`define JIB_ID_REV_LSB 28
`define JIB_ID_REV_W 4

// register byte offsets
`define JIB_ADDR_W 8
`define JIB_OFS_IDWORD 8'h00
`define JIB_OFS_PINLVL 8'h04
`define JIB_OFS_COREOUT 8'h08
`define JIB_OFS_COREOE 8'h0c
`define JIB_OFS_STATUS 8'h10

// reset values and status field layout
`define JIB_RST_COREOUT 32'h0000_0000
`define JIB_RST_COREOE 32'h0000_0000
`define JIB_STAT_EXTEST_POS 0
`define JIB_STAT_UPDCNT_LSB 8
`define JIB_UPDCNT_W 8

`endif

/* jib_pkg.sv */
package jib_pkg;

   // active instruction as decoded by the tap controller
   typedef enum logic [2:0] {
      INS_BYPASS = 3'h0,
      INS_IDCODE = 3'h1,
      INS_EXTEST = 3'h3,
      INS_SAMPLE = 3'h2,
      INS_PRELOAD = 3'h6,
      INS_SAMPLE_PRELOAD = 3'h7
   } jib_instr_e;

   // one-hot data-register phase strobes from the tap controller
   typedef struct packed {
      logic captureDr;
      logic shiftDr;
      logic updateDr;
   } jib_tapctl_s;

   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } jib_busreq_s;

endpackage : jib_pkg

/* jib_scan_path.sv */
`timescale 1ns/1ns
`include "jib_defs.svh"

module jib_scan_path
   import jib_pkg::*;
#(
   parameter int NIN = 4,
   parameter int NBI = 4,
   parameter logic [`JIB_ID_REV_W-1:0] REVISION = 4'h3, // arbitrary value
   parameter logic [`JIB_ID_CENTER_W-1:0] CENTER = 6'h15, // arbitrary value
   parameter logic [`JIB_ID_PART_W-1:0] PART = 10'h1a5, // arbitrary value
   parameter logic [`JIB_ID_MAKER_W-1:0] MAKER = 11'h2b3 // arbitrary value
) (
   // system clock and register port
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire jib_busreq_s busReq,
   output logic [31:0] busRdata,
   // test access port
   input wire logic tck,
   input wire logic tapRst,
   input wire jib_tapctl_s tapCtl,
   input wire jib_instr_e tapInstr,
   input wire logic tdi,
   output logic tdo,
   output logic tdoEn,
   // device pins
   input wire logic [NIN-1:0] pinIn,
   input wire logic [NBI-1:0] padIn,
   output logic [NBI-1:0] padOut,
   output logic [NBI-1:0] padOe
);

   localparam int BSR_LEN = NIN + 2 * NBI;
   localparam int OUT_LEN = 2 * NBI;
   localparam logic [`JIB_ID_W-1:0] ID_WORD =
      {REVISION, CENTER, PART, MAKER, 1'b1};

   ////////////////////////////////////////////////////////////////////////////
   // test clock domain

   logic [1:0] rstSync_q;
   logic tckRst;
   logic selId;
   logic selBsr;
   logic bsrUpd;
   logic [NIN-1:0] pinT1_q, pinT_q;
   logic [NBI-1:0] padT1_q, padT_q;
   logic [NBI-1:0] oeT1_q, oeT_q;
   logic [`JIB_ID_W-1:0] idShift_q;
   logic [BSR_LEN-1:0] bsrShift_q;
   logic [OUT_LEN-1:0] updLatch_q;
   logic updTgl_q;
   logic extestT_q;
   logic tdo_q, tdoEn_q;
   logic shOut_q;

   // system reset reaches the test domain through two flops; the test
   // clock must tick a few times during reset for it to arrive
   always_ff @(posedge tck) begin
      rstSync_q <= {rstSync_q[0], sys_rst};
   end

   assign tckRst = rstSync_q[1] | tapRst;
   assign selId = (tapInstr == INS_IDCODE);
   assign selBsr = (tapInstr == INS_EXTEST) || (tapInstr == INS_SAMPLE) ||
      (tapInstr == INS_PRELOAD) || (tapInstr == INS_SAMPLE_PRELOAD);
   // plain sample observes only, so it leaves the output cells alone
   assign bsrUpd = (tapInstr == INS_EXTEST) || (tapInstr == INS_PRELOAD) ||
      (tapInstr == INS_SAMPLE_PRELOAD);

   // pins and the pad enables are foreign to the test clock
   always_ff @(posedge tck) begin
      pinT1_q <= pinIn;
      pinT_q <= pinT1_q;
      padT1_q <= padIn;
      padT_q <= padT1_q;
      oeT1_q <= padOe;
      oeT_q <= oeT1_q;
   end

   always_ff @(posedge tck) begin
      if (tckRst) begin
         idShift_q <= '0;
      end else if (tapCtl.captureDr && selId) begin
         idShift_q <= ID_WORD;
      end else if (tapCtl.shiftDr && selId) begin
         idShift_q <= {tdi, idShift_q[`JIB_ID_W-1:1]};
      end
   end

   // cells: inputs low, then two-way data, then two-way direction
   always_ff @(posedge tck) begin
      if (tckRst) begin
         bsrShift_q <= '0;
      end else if (tapCtl.captureDr && selBsr) begin
         bsrShift_q <= {oeT_q, padT_q, pinT_q};
      end else if (tapCtl.shiftDr && selBsr) begin
         bsrShift_q <= {tdi, bsrShift_q[BSR_LEN-1:1]};
      end
   end

   // update stage holds the output cells still while shifting; the id
   // register has no update stage, so nothing here reacts to it
   always_ff @(posedge tck) begin
      if (tckRst) begin
         updLatch_q <= '0;
         updTgl_q <= 1'b0;
      end else if (tapCtl.updateDr && bsrUpd) begin
         updLatch_q <= bsrShift_q[BSR_LEN-1:NIN];
         updTgl_q <= ~updTgl_q;
      end
   end

   always_ff @(posedge tck) begin
      if (tckRst) begin
         extestT_q <= 1'b0;
      end else begin
         extestT_q <= (tapInstr == INS_EXTEST);
      end
   end

   // catch the bit that the shift pushes out; by the falling edge the
   // shifter has already moved on and bit 0 would be lost
   always_ff @(posedge tck) begin
      if (tckRst) begin
         shOut_q <= 1'b0;
      end else if (tapCtl.shiftDr && selId) begin
         shOut_q <= idShift_q[0];
      end else if (tapCtl.shiftDr && selBsr) begin
         shOut_q <= bsrShift_q[0];
      end
   end

   // tdo changes on the falling edge; the probe reads it 13 ns after that edge
   always_ff @(negedge tck) begin
      if (tckRst) begin
         tdo_q <= 1'b0;
         tdoEn_q <= 1'b0;
      end else if (tapCtl.shiftDr && selId) begin
         tdo_q <= shOut_q;
         tdoEn_q <= 1'b1;
      end else if (tapCtl.shiftDr && selBsr) begin
         tdo_q <= shOut_q;
         tdoEn_q <= 1'b1;
      end else begin
         tdo_q <= 1'b0;
         tdoEn_q <= 1'b0;
      end
   end

   assign tdo = tdo_q;
   assign tdoEn = tdoEn_q;

   ////////////////////////////////////////////////////////////////////////////
   // system clock domain

   logic [1:0] extSync_q;
   logic [2:0] tglSync_q;
   logic [OUT_LEN-1:0] latchCopy_q;
   logic [NIN-1:0] pinS1_q, pinS_q;
   logic [NBI-1:0] padS1_q, padS_q;
   logic [31:0] coreOut_q, coreOe_q;
   logic [`JIB_UPDCNT_W-1:0] updCnt_q;
   logic [NBI-1:0] padOut_q, padOe_q;
   logic [31:0] rdata_q;
   logic updSeen;

   always_ff @(posedge sys_clk) begin
      extSync_q <= {extSync_q[0], extestT_q};
      tglSync_q <= {tglSync_q[1:0], updTgl_q};
      pinS1_q <= pinIn;
      pinS_q <= pinS1_q;
      padS1_q <= padIn;
      padS_q <= padS1_q;
   end

   assign updSeen = tglSync_q[2] ^ tglSync_q[1];

   // the latch word is stable for a whole scan after each toggle, far
   // longer than the three system cycles the toggle needs to arrive
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         latchCopy_q <= '0;
         updCnt_q <= '0;
      end else if (updSeen) begin
         latchCopy_q <= updLatch_q;
         updCnt_q <= updCnt_q + `JIB_UPDCNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         padOut_q <= '0;
         padOe_q <= '0;
      end else if (extSync_q[1]) begin
         padOut_q <= latchCopy_q[NBI-1:0];
         padOe_q <= latchCopy_q[OUT_LEN-1:NBI];
      end else begin
         padOut_q <= coreOut_q[NBI-1:0];
         padOe_q <= coreOe_q[NBI-1:0];
      end
   end

   assign padOut = padOut_q;
   assign padOe = padOe_q;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         coreOut_q <= `JIB_RST_COREOUT;
         coreOe_q <= `JIB_RST_COREOE;
      end else if (busReq.wr) begin
         if (busReq.addr == `JIB_OFS_COREOUT) begin
            coreOut_q <= busReq.wdata;
         end
         if (busReq.addr == `JIB_OFS_COREOE) begin
            coreOe_q <= busReq.wdata;
         end
      end
   end

   // read data stands for one cycle after each cycle that rd is high, zero otherwise
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !busReq.rd) begin
         rdata_q <= '0;
      end else begin
         case (busReq.addr)
            `JIB_OFS_IDWORD: rdata_q <= ID_WORD;
            `JIB_OFS_PINLVL: rdata_q <= 32'({padS_q, pinS_q});
            `JIB_OFS_COREOUT: rdata_q <= coreOut_q;
            `JIB_OFS_COREOE: rdata_q <= coreOe_q;
            `JIB_OFS_STATUS: rdata_q <= 32'({updCnt_q, 7'h00, extSync_q[1]});
            default: rdata_q <= '0;
         endcase
      end
   end

   assign busRdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   sequence s_idCapture;
      tapCtl.captureDr && selId;
   endsequence

   sequence s_bsrCapture;
      tapCtl.captureDr && selBsr;
   endsequence

   property p_idRoute;
      @(posedge tck) disable iff (tckRst)
      tapCtl.shiftDr && selId |=> tdoEn_q && tdo_q == $past(idShift_q[0]);
   endproperty
   a_idRoute: assert property (p_idRoute)
      else $error("id bit not on tdo during shift");

   property p_idCapture;
      @(posedge tck) disable iff (tckRst)
      s_idCapture |=> idShift_q == ID_WORD;
   endproperty
   a_idCapture: assert property (p_idCapture)
      else $error("id word not loaded at capture");

   property p_idShift;
      @(posedge tck) disable iff (tckRst)
      s_idCapture ##1 (tapCtl.shiftDr && selId) |=>
         idShift_q == {$past(tdi), ID_WORD[`JIB_ID_W-1:1]};
   endproperty
   a_idShift: assert property (p_idShift)
      else $error("first id shift wrong");

   property p_idNoUpdate;
      @(posedge tck) disable iff (tckRst)
      tapCtl.updateDr && selId |=> $stable(updLatch_q) && $stable(updTgl_q);
   endproperty
   a_idNoUpdate: assert property (p_idNoUpdate)
      else $error("update stage moved under id");

   property p_idMarker;
      @(posedge tck) disable iff (tckRst)
      s_idCapture |=> idShift_q[`JIB_ID_MARK_POS] == 1'b1;
   endproperty
   a_idMarker: assert property (p_idMarker)
      else $error("id marker bit not one");

   property p_idRev;
      @(posedge tck) disable iff (tckRst)
      s_idCapture |=>
         idShift_q[`JIB_ID_REV_LSB +: `JIB_ID_REV_W] == REVISION;
   endproperty
   a_idRev: assert property (p_idRev)
      else $error("revision field wrong");

   property p_idCenter;
      @(posedge tck) disable iff (tckRst)
      s_idCapture |=>
         idShift_q[`JIB_ID_CENTER_LSB +: `JIB_ID_CENTER_W] == CENTER;
   endproperty
   a_idCenter: assert property (p_idCenter)
      else $error("design center field wrong");

   property p_idPart;
      @(posedge tck) disable iff (tckRst)
      s_idCapture |=> idShift_q[`JIB_ID_PART_LSB +: `JIB_ID_PART_W] == PART;
   endproperty
   a_idPart: assert property (p_idPart)
      else $error("part field wrong");

   property p_idMaker;
      @(posedge tck) disable iff (tckRst)
      s_idCapture |=>
         idShift_q[`JIB_ID_MAKER_LSB +: `JIB_ID_MAKER_W] == MAKER;
   endproperty
   a_idMaker: assert property (p_idMaker)
      else $error("maker field wrong");

   property p_bsrShift;
      @(posedge tck) disable iff (tckRst)
      tapCtl.shiftDr && selBsr |=>
         bsrShift_q == {$past(tdi), $past(bsrShift_q[BSR_LEN-1:1])};
   endproperty
   a_bsrShift: assert property (p_bsrShift)
      else $error("boundary register not shifting");

   property p_bsrCapIn;
      @(posedge tck) disable iff (tckRst)
      s_bsrCapture |=> bsrShift_q[NIN-1:0] == $past(pinT_q);
   endproperty
   a_bsrCapIn: assert property (p_bsrCapIn)
      else $error("input pins not captured");

   property p_bsrCells;
      @(posedge tck) disable iff (tckRst)
      s_bsrCapture |=> bsrShift_q[NIN +: NBI] == $past(padT_q) &&
         bsrShift_q[NIN + NBI +: NBI] == $past(oeT_q);
   endproperty
   a_bsrCells: assert property (p_bsrCells)
      else $error("two-way cells mapped wrong");

   property p_extestDrive;
      @(posedge sys_clk) disable iff (sys_rst)
      extSync_q[1] |=> padOut_q == $past(latchCopy_q[NBI-1:0]) &&
         padOe_q == $past(latchCopy_q[OUT_LEN-1:NBI]);
   endproperty
   a_extestDrive: assert property (p_extestDrive)
      else $error("pads not driven from update stage");

endmodule : jib_scan_path

/* jib_probe.sv */
`timescale 1ns/1ns
module jib_probe
   import jib_pkg::*;
(
   // test access port, driven side
   output logic tck,
   output logic tapRst,
   output jib_tapctl_s tapCtl,
   output jib_instr_e tapInstr,
   output logic tdi,
   // returned serial data
   input wire logic tdo,
   input wire logic tdoEn
);
   initial begin
      tck = 1'b0;
      tapRst = 1'b0;
      tapCtl = '0;
      tapInstr = INS_BYPASS;
      tdi = 1'b0;
   end

   // one 64 ns period; the clock rests low between frames
   task automatic pulse();
      #19 tck = 1'b1;
      #32 tck = 1'b0;
      #13;
   endtask : pulse

   task automatic reset();
      tapRst = 1'b1;
      repeat (3) pulse();
      tapRst = 1'b0;
   endtask : reset

   // capture, n shifts lsb first, update; tdo read after each negedge
   task automatic scan(input jib_instr_e ins, input int n,
         input logic [63:0] din, output logic [63:0] dout,
         output int enCnt);
      dout = '0;
      enCnt = 0;
      tapInstr = ins;
      tapCtl = '{captureDr: 1'b1, shiftDr: 1'b0, updateDr: 1'b0};
      pulse();
      tapCtl = '{captureDr: 1'b0, shiftDr: 1'b1, updateDr: 1'b0};
      for (int i = 0; i < n; i++) begin
         tdi = din[i];
         pulse();
         dout[i] = tdo;
         enCnt += int'(tdoEn === 1'b1);
      end
      tapCtl = '{captureDr: 1'b0, shiftDr: 1'b0, updateDr: 1'b1};
      // a released line must not keep showing the last bit
      tdi = ~tdi;
      pulse();
      tapCtl = '0;
      pulse();
   endtask : scan
endmodule : jib_probe

/* tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   import jib_pkg::*;
   localparam logic [3:0] REV = 4'h6; // arbitrary value
   localparam logic [5:0] CTR = 6'h2a; // arbitrary value
   localparam logic [9:0] PRT = 10'h0c3; // arbitrary value
   localparam logic [10:0] MKR = 11'h15d; // arbitrary value
   localparam logic [31:0] ID_WORD = {REV, CTR, PRT, MKR, 1'b1};
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   jib_busreq_s busReq = '0;
   logic [31:0] busRdata, rv;
   logic tck, tapRst, tdi, tdo, tdoEn;
   jib_tapctl_s tapCtl;
   jib_instr_e tapInstr;
   logic [3:0] pinIn = 4'ha;
   logic [3:0] extLvl = 4'h5;
   logic [3:0] padIn, padOut, padOe;
   logic [63:0] dout;
   int failures = 0;
   int tests_run = 0;
   int cycles = 0;
   int enCnt;

   always #5 sys_clk = ~sys_clk;
   // a pad the chip drives shows its own level, others the board's
   assign padIn = (padOut & padOe) | (extLvl & ~padOe);

   jib_scan_path #(.NIN(4), .NBI(4), .REVISION(REV), .CENTER(CTR),
      .PART(PRT), .MAKER(MKR)) i_jib_scan_path (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .busReq(busReq), .busRdata(busRdata),
      .tck(tck), .tapRst(tapRst), .tapCtl(tapCtl), .tapInstr(tapInstr),
      .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn), .pinIn(pinIn),
      .padIn(padIn), .padOut(padOut), .padOe(padOe));
   jib_probe i_jib_probe (.tck(tck), .tapRst(tapRst), .tapCtl(tapCtl),
      .tapInstr(tapInstr), .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn));

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk) busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk) busReq <= '0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge sys_clk) busReq <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk) busReq <= '0;
      #1 v = busRdata;
   endtask : rd

   task automatic t_id_reg();
      rd(8'h00, rv);
      check(rv[0], 1'b1);
      check(rv[31:28], REV);
      check(rv[27:22], CTR);
      check(rv[21:12], PRT);
      check(rv[11:1], MKR);
      check(rv, ID_WORD);
      wr(8'h00, 32'h0000_0000);
      rd(8'h00, rv);
      check(rv, ID_WORD);
      rd(8'h20, rv);
      check(rv, 32'h0);
   endtask : t_id_reg

   task automatic t_id_scan();
      wr(8'h08, 32'h0000_0009);
      wr(8'h0c, 32'h0000_0003);
      i_jib_probe.scan(INS_IDCODE, 40, 64'h5c, dout, enCnt);
      check(dout[31:0], ID_WORD);
      check(dout[39:32], 8'h5c);
      check(enCnt, 40);
      // back to back: the second capture must reload the word
      i_jib_probe.scan(INS_IDCODE, 32, 64'h0, dout, enCnt);
      check(dout[31:0], ID_WORD);
      repeat (10) @(posedge sys_clk);
      check({padOe, padOut}, 8'h39);
      i_jib_probe.scan(INS_BYPASS, 8, 64'hff, dout, enCnt);
      check(enCnt, 0);
   endtask : t_id_scan

   task automatic t_sample();
      rd(8'h04, rv);
      check(rv[7:0], {padIn, pinIn});
      i_jib_probe.scan(INS_SAMPLE, 20, 64'hac03c, dout, enCnt);
      check(dout[3:0], pinIn);
      check(dout[7:4], 4'h5);
      check(dout[11:8], 4'h3);
      check(dout[19:12], 8'h3c);
      repeat (10) @(posedge sys_clk);
      check({padOe, padOut}, 8'h39);
   endtask : t_sample

   task automatic t_extest();
      jib_instr_e ins[3] = '{INS_PRELOAD, INS_SAMPLE_PRELOAD, INS_EXTEST};
      foreach (ins[k]) begin
         i_jib_probe.scan(ins[k], 20, 64'hac03c, dout, enCnt);
         check(dout[19:12], 8'h3c);
         check(enCnt, 20);
         check(dout[3:0], pinIn);
      end
      repeat (10) @(posedge sys_clk);
      check({padOe, padOut}, 8'hac);
      rd(8'h10, rv);
      check(rv[0], 1'b1);
      check(rv[15:8], 8'h03);
      i_jib_probe.scan(INS_IDCODE, 32, 64'h0, dout, enCnt);
      repeat (10) @(posedge sys_clk);
      check({padOe, padOut}, 8'h39);
   endtask : t_extest

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish

   // the whole run needs some 1500 cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      i_jib_probe.reset();
      check({busRdata, padOe, padOut, tdoEn}, '0);
      t_id_reg();
      t_id_scan();
      t_sample();
      t_extest();
      tally_and_finish();
   end
endmodule : tb_top
